//--- hdl/ifou_pkg.sv
/*
 * constants, types and field layout of the upper input frame offset block
 * (streams 4 to 7): register map, reset values, bit-cell timing.
 * assumes a single system clock and an avalon-mm register bus.
 */
// Function
// - four nibbles: three offset bits, edge bit lowest
// - offset bits delay bit 0 capture
// - delay counted from frame pulse, up to 4.5
// - shift equals offset plus half when edge set
// - zero offset, edge set gives half period
// - offset codes above four are not valid
// - offset register at index four, resets zero
package ifou_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam int unsigned IFOU_ADDR_W = 8;
    localparam logic [7:0] IFOU_IDX_OFFSET = 8'h04; // offset register index
    localparam logic [7:0] IFOU_IDX_STATUS = 8'h05; // stream status index
    localparam logic [7:0] IFOU_ADDR_OFFSET = 8'h10; // byte address, index times four
    localparam logic [7:0] IFOU_ADDR_STATUS = 8'h14;
    localparam logic [15:0] IFOU_OFFSET_RST = 16'h0000;
    localparam logic [31:0] IFOU_RDATA_RST = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int unsigned IFOU_STREAMS = 4;
    localparam int unsigned IFOU_SLOT_W = 4;
    localparam int unsigned IFOU_LATCH_POS = 0;
    localparam int unsigned IFOU_OFS_LSB = 1;
    localparam int unsigned IFOU_STAT_GCI_POS = 4;
    localparam logic [2:0] IFOU_OFS_MAX = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // timing: link edges are half clock periods
    localparam logic [3:0] IFOU_HALF_MAX = 4'h9; // 4.5 clock periods
    localparam logic [1:0] IFOU_PHASE_MID = 2'h1; // mid-cell edge, half of a bit cell
    localparam logic [1:0] IFOU_PHASE_TQ = 2'h2; // three-quarter edge
    localparam logic [2:0] IFOU_BIT_LAST = 3'h7;

    typedef struct packed {
        logic [2:0] offset;
        logic latch;
    } ifou_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic start;
    } ifou_rx_t;

endpackage

//--- hdl/ifou_stream.sv
/*
 * one serial receiver: delays frame start by the programmed half periods,
 * then shifts in bits on the selected edge and emits bytes.
 * assumes edge pulses and data already synchronised to clk_sys.
 */
module ifou_stream (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic linkRise,
    input wire logic linkFall,
    input wire logic frameRef,
    input wire logic gciMode,
    input wire logic rxBit,
    input wire ifou_pkg::ifou_cfg_t cfg,
    output ifou_pkg::ifou_rx_t rxOut
);
    import ifou_pkg::*;

    logic armed_q, armed_d;
    logic running_q, running_d;
    logic [3:0] waitCnt_q, waitCnt_d;
    logic [1:0] phase_q, phase_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d;
    ifou_rx_t out_q, out_d;

    ////////////////////////////////////////////////////////////////////////////
    // delay in half periods, undefined codes held at the largest valid one
    wire logic [2:0] ofsEff = (cfg.offset > IFOU_OFS_MAX) ? IFOU_OFS_MAX : cfg.offset;
    wire logic [3:0] delayHalf = {ofsEff, cfg.latch};
    wire logic anyEdge = linkRise | linkFall;
    wire logic [3:0] waitNext = waitCnt_q + 4'h1;
    wire logic startNow = (frameRef & (delayHalf == 4'h0))
        | (armed_q & anyEdge & (waitNext == delayHalf));
    // edge choice by mode and edge bit
    wire logic selEdge = gciMode ? (cfg.latch ? linkRise : linkFall)
                                 : (cfg.latch ? linkFall : linkRise);
    wire logic sampleNow = running_q & ~startNow & selEdge
        & ((phase_q == IFOU_PHASE_MID) | (phase_q == IFOU_PHASE_TQ));
    wire logic [7:0] shiftNext = {shift_q[6:0], rxBit};

    ////////////////////////////////////////////////////////////////////////////
    // frame start delay and bit-cell tracking
    always_comb begin
        armed_d = armed_q;
        waitCnt_d = waitCnt_q;
        running_d = running_q;
        phase_d = phase_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        out_d = '0;
        out_d.data = out_q.data;
        if (frameRef) begin
            armed_d = (delayHalf != 4'h0);
            waitCnt_d = 4'h0;
        end else if (armed_q & anyEdge) begin
            waitCnt_d = waitNext;
            if (waitNext == delayHalf) begin
                armed_d = 1'b0;
            end
        end
        if (startNow) begin
            running_d = 1'b1;
            phase_d = 2'h0;
            bitCnt_d = 3'h0;
            out_d.start = 1'b1;
        end else if (running_q & anyEdge) begin
            phase_d = phase_q + 2'h1;
        end
        if (sampleNow) begin
            shift_d = shiftNext;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == IFOU_BIT_LAST) begin
                out_d.data = shiftNext;
                out_d.valid = 1'b1;
            end
        end
    end

    // state registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
            waitCnt_q <= 4'h0;
            running_q <= 1'b0;
            phase_q <= 2'h0;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            out_q <= '0;
        end else begin
            armed_q <= armed_d;
            waitCnt_q <= waitCnt_d;
            running_q <= running_d;
            phase_q <= phase_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            out_q <= out_d;
        end
    end

    assign rxOut = out_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_zero_delay;
        @(posedge clk_sys) disable iff (!rst_b)
        (frameRef && delayHalf == 4'h0) |=> rxOut.start;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay start late");

    property p_max_delay;
        @(posedge clk_sys) disable iff (!rst_b)
        delayHalf <= IFOU_HALF_MAX;
    endproperty
    a_max_delay: assert property (p_max_delay) else $error("delay beyond 4.5 periods");

    property p_wait_bound;
        @(posedge clk_sys) disable iff (!rst_b)
        armed_q |-> waitCnt_q < delayHalf;
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("wait count overran delay");

    property p_half_start;
        @(posedge clk_sys) disable iff (!rst_b)
        (frameRef && delayHalf == 4'h1) |-> ##[2:8] rxOut.start;
    endproperty
    a_half_start: assert property (p_half_start) else $error("half period start missed");

    property p_edge_type;
        @(posedge clk_sys) disable iff (!rst_b)
        sampleNow |-> (gciMode ^ cfg.latch) ? linkFall : linkRise;
    endproperty
    a_edge_type: assert property (p_edge_type) else $error("sample on wrong edge");
endmodule

//--- hdl/ifou_top.sv
/*
 * upper input frame offset block: avalon-mm slave holding the offset
 * register for streams 4 to 7, pin synchronisers and four receivers.
 * assumes link clock, frame pulse, mode and data pins are asynchronous
 * to clk_sys and that the link clock is much slower than clk_sys.
 */
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
module ifou_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [ifou_pkg::IFOU_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic linkClk,
    input wire logic framePulseIn_b,
    input wire logic gciModeIn,
    input wire logic [3:0] rxPin,
    output ifou_pkg::ifou_rx_t [3:0] rxOut
);
    import ifou_pkg::*;

    logic [15:0] offset_q, offset_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q;
    logic [6:0] syncA_q, syncB_q;
    logic linkPrev_q;
    logic frameHeld_q;
    logic [3:0] aligned_q;

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers: link clock, frame pulse, mode, four data pins
    wire logic [6:0] pinsRaw = {rxPin, gciModeIn, framePulseIn_b, linkClk};
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= 7'h06; // idle: frame pulse and mode high
            syncB_q <= 7'h06;
        end else begin
            syncA_q <= pinsRaw;
            syncB_q <= syncA_q;
        end
    end

    wire logic linkS = syncB_q[0];
    wire logic frameS_b = syncB_q[1];
    wire logic gciS = syncB_q[2];
    wire logic [3:0] rxS = syncB_q[6:3];

    ////////////////////////////////////////////////////////////////////////////
    // link edges and the frame reference edge
    wire logic linkRise = linkS & ~linkPrev_q;
    wire logic linkFall = ~linkS & linkPrev_q;
    wire logic frameAct = gciS ? frameS_b : ~frameS_b; // active high in gci mode
    wire logic refEdge = gciS ? linkRise : linkFall;
    wire logic frameRef = refEdge & frameAct & ~frameHeld_q;

    // edge history and one reference per frame pulse
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            linkPrev_q <= 1'b0;
            frameHeld_q <= 1'b0;
        end else begin
            linkPrev_q <= linkS;
            frameHeld_q <= frameAct & (frameHeld_q | refEdge);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon decode: one wait state, then answer
    wire logic busReq = avs_read | avs_write;
    wire logic hitOffset = (avs_address == IFOU_ADDR_OFFSET);
    wire logic hitStatus = (avs_address == IFOU_ADDR_STATUS);
    wire logic doWrite = avs_write & ack_q & hitOffset;
    wire logic [31:0] statusWord = {27'h0, gciS, aligned_q};
    assign avs_waitrequest = busReq & ~ack_q;

    // register write by byte lane, read data staged before the answer edge
    always_comb begin
        offset_d = offset_q;
        if (doWrite & avs_byteenable[0]) begin
            offset_d[7:0] = avs_writedata[7:0];
        end
        if (doWrite & avs_byteenable[1]) begin
            offset_d[15:8] = avs_writedata[15:8];
        end
        rdata_d = rdata_q;
        if (avs_read & ~ack_q) begin
            rdata_d = hitOffset ? {16'h0, offset_q} : hitStatus ? statusWord : 32'h0;
        end
    end

    // bus registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            offset_q <= IFOU_OFFSET_RST;
            rdata_q <= IFOU_RDATA_RST;
            ack_q <= 1'b0;
        end else begin
            offset_q <= offset_d;
            rdata_q <= rdata_d;
            ack_q <= busReq & ~ack_q;
        end
    end

    assign avs_readdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // receivers, stream 4 in the low nibble
    genvar gi;
    generate
        for (gi = 0; gi < IFOU_STREAMS; gi++) begin : g_stream
            ifou_cfg_t cfg;
            assign cfg.latch = offset_q[gi*IFOU_SLOT_W+IFOU_LATCH_POS];
            assign cfg.offset = offset_q[gi*IFOU_SLOT_W+IFOU_OFS_LSB +: 3];
            ifou_stream u_stream (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .linkRise(linkRise),
                .linkFall(linkFall),
                .frameRef(frameRef),
                .gciMode(gciS),
                .rxBit(rxS[gi]),
                .cfg(cfg),
                .rxOut(rxOut[gi])
            );
        end
    endgenerate

    // per-stream frame seen since reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aligned_q <= 4'h0;
        end else begin
            aligned_q <= aligned_q | {rxOut[3].start, rxOut[2].start,
                                      rxOut[1].start, rxOut[0].start};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_write_req;
        avs_write && hitOffset && avs_byteenable[1:0] == 2'h3 && !avs_waitrequest;
    endsequence

    property p_write_lands;
        @(posedge clk_sys) disable iff (!rst_b)
        s_write_req |=> offset_q == $past(avs_writedata[15:0]);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("offset write lost");

    property p_read_back;
        @(posedge clk_sys) disable iff (!rst_b)
        (avs_read && hitOffset && !avs_waitrequest)
            |-> avs_readdata == {16'h0, $past(offset_q)};
    endproperty
    a_read_back: assert property (p_read_back) else $error("offset read wrong");

    property p_slot_map;
        @(posedge clk_sys) disable iff (!rst_b)
        g_stream[3].cfg == offset_q[15:12];
    endproperty
    a_slot_map: assert property (p_slot_map) else $error("stream seven slot misplaced");

    property p_one_wait;
        @(posedge clk_sys) disable iff (!rst_b)
        ($rose(busReq) || (busReq && !$past(avs_waitrequest)))
            |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer timing wrong");
endmodule

//--- sim/ifou_link_model.sv
/*
 * far side of the block: free-running link clock, frame pulse and four
 * serial data lines, each frame laid out from the programmed delays.
 * assumes it shares clk_sys with the bench; pins move on link edges only.
 */
module ifou_link_model (
    input wire logic clk_sys,
    input wire logic gci,
    input wire logic go,
    input wire logic [3:0][3:0] dly,
    input wire logic [7:0] byteA,
    input wire logic [7:0] byteB,
    output logic linkClk,
    output logic framePulseIn_b,
    output logic [3:0] rxPin
);
    timeunit 1ns;
    timeprecision 1ps;
    int sc = 0;
    int h = 0;
    int refH = -100;
    int hn;
    int r;
    logic act;

    // quiet pins at time zero
    initial begin
        linkClk = 1'b0;
        framePulseIn_b = 1'b1;
        rxPin = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // half link period is 4 clk_sys cycles; bit cell is 4 halves
    always @(posedge clk_sys) begin
        hn = (sc == 3) ? h + 1 : h;
        if (go) refH <= h + 4 + ((h + 4 + gci) % 2); // falling ref, rising in gci
        sc <= (sc + 1) % 4;
        h <= hn;
        linkClk <= hn[0];
        act = (hn - refH == -1) || (hn - refH == 0);
        framePulseIn_b <= gci ? act : !act; // low active, high in gci
        for (int k = 0; k < 4; k++) begin
            r = hn - refH - dly[k]; // bit 0 lands dly halves after
            // true bit only in the last quarter of a cell, the three-quarter edge
            if (r >= 0 && r < 32) rxPin[k] <= (r % 4 < 3) ? byteA[7 - r / 4]
                                                          : byteB[7 - r / 4];
            else rxPin[k] <= hn[0]; // idle line toggles
        end
    end
endmodule

//--- sim/testbench.sv
/*
 * bench for the upper frame offset block: avalon-mm accesses, then frames
 * in both modes with every valid offset setting, checking start and first byte.
 * assumes the link partner model and one wait state per access.
 */
module testbench;
    import ifou_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic linkClk;
    logic framePulseIn_b;
    logic gciModeIn = 1'b0;
    logic go = 1'b0;
    logic [3:0] rxPin;
    ifou_rx_t [3:0] rxOut;
    logic [3:0][3:0] dly = '0;
    logic [7:0] byteA = 8'h00;
    logic [7:0] byteB = 8'h00;
    logic [15:0] tbl [3] = '{16'h3210, 16'h6540, 16'h9870};
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int startCyc [4];
    logic [7:0] gotByte [4];
    logic [3:0] started = 4'h0;
    logic [3:0] gotV = 4'h0;
    logic [31:0] q;

    ifou_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .linkClk(linkClk),
        .framePulseIn_b(framePulseIn_b), .gciModeIn(gciModeIn), .rxPin(rxPin),
        .rxOut(rxOut));
    ifou_link_model link (.clk_sys(clk_sys), .gci(gciModeIn), .go(go), .dly(dly),
        .byteA(byteA), .byteB(byteB), .linkClk(linkClk),
        .framePulseIn_b(framePulseIn_b), .rxPin(rxPin));

    // 125 MHz system clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    // record start pulse cycle and first byte of each stream
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 4; k++) begin
            if (rxOut[k].start === 1'b1) begin
                startCyc[k] = cyc;
                started[k] = 1'b1;
            end
            if (rxOut[k].valid === 1'b1 && started[k] && !gotV[k]) begin
                gotByte[k] = rxOut[k].data;
                gotV[k] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task close_out;
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is seen low at a rising edge
    task av(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                close_out();
            end
            @(posedge clk_sys);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        av(1'b0, a, 32'h00000000, 4'hF);
        chk(q, exp);
    endtask

    // expected shift in half link periods, codes above four clamped
    function automatic logic [3:0] ehalf(input logic [3:0] nib);
        ehalf = {(nib[3:1] > IFOU_OFS_MAX) ? IFOU_OFS_MAX : nib[3:1], 1'b0} + nib[0];
    endfunction

    // setting from a delay measurement: delay bits high, inverted phase bit lowest
    function automatic logic [3:0] conv(input logic ph, input logic [2:0] d);
        conv = {d, ~ph};
    endfunction

    // program all four slots, send one frame, compare start spacing against stream 4 and every byte against byteB
    task run_frame(input logic [15:0] w);
        int n;
        av(1'b1, IFOU_ADDR_OFFSET, {16'h0000, w}, 4'h3);
        rd(IFOU_ADDR_OFFSET, {16'h0000, w});
        for (int k = 0; k < 4; k++) dly[k] <= ehalf(w[4 * k +: 4]);
        byteB <= 8'h5A + w[7:0];
        byteA <= ~(8'h5A + w[7:0]);
        started = 4'h0;
        gotV = 4'h0;
        @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        n = 0;
        while (gotV !== 4'hF) begin
            @(posedge clk_sys);
            n++;
            if (n > 600) begin
                error_cnt++;
                close_out();
            end
        end
        for (int k = 1; k < 4; k++) begin
            chk(startCyc[k] - startCyc[0], 4 * (dly[k] - dly[0]));
        end
        for (int k = 0; k < 4; k++) chk(gotByte[k], byteB);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // register checks, frames in both modes, then a second reset
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(IFOU_ADDR_OFFSET, 32'h00000000);
        rd(IFOU_ADDR_STATUS, 32'h00000000);
        av(1'b1, IFOU_ADDR_OFFSET, 32'hFFFFABCD, 4'h1);
        rd(IFOU_ADDR_OFFSET, 32'h000000CD);
        av(1'b1, IFOU_ADDR_OFFSET, 32'h00001200, 4'h2);
        rd(IFOU_ADDR_OFFSET, 32'h000012CD);
        av(1'b1, 8'h20, 32'h0000FFFF, 4'hF);
        rd(8'h20, 32'h00000000);
        rd(IFOU_ADDR_OFFSET, 32'h000012CD);
        av(1'b1, IFOU_ADDR_STATUS, 32'h000000FF, 4'hF);
        rd(IFOU_ADDR_STATUS, 32'h00000000);
        for (int m = 0; m < 2; m++) begin
            gciModeIn <= m[0];
            repeat (300) @(posedge clk_sys);
            for (int f = 0; f < 3; f++) run_frame(tbl[f]);
            // measured phase and delay converted as software would
            run_frame({conv(1'b1, 3'h0), conv(1'b0, 3'h1), conv(1'b0, 3'h2),
                conv(1'b0, 3'h4)});
        end
        rd(IFOU_ADDR_STATUS, 32'h0000001F);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(IFOU_ADDR_OFFSET, 32'h00000000);
        rd(IFOU_ADDR_STATUS, 32'h00000010);
        close_out();
    end
endmodule
